/* src/ssx_map.svh */
`ifndef SSX_MAP_SVH
`define SSX_MAP_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SSX_OFF_CTRL 8'h00
`define SSX_OFF_OPERAND 8'h04
`define SSX_OFF_EXEC 8'h08
`define SSX_OFF_WORK 8'h0c
`define SSX_OFF_STATUS 8'h10
`define SSX_OFF_FADDR 8'h14
`define SSX_OFF_FDATA 8'h18
`define SSX_OFF_DIR 8'h1c
`define SSX_OFF_RESULT 8'h20
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SSX_CTRL_OP_LSB 0
`define SSX_CTRL_DEST_BIT 3
`define SSX_OPND_FILE_LSB 0
`define SSX_OPND_LIT_LSB 8
`define SSX_STAT_C_BIT 0
`define SSX_STAT_DC_BIT 1
`define SSX_STAT_Z_BIT 2
`define SSX_DIR_PORT_LSB 8
// ---------------------------------------------------------------
// Reset values and constants
// ---------------------------------------------------------------
`define SSX_RST_BYTE 8'h00
`define SSX_RST_DIR 8'hff
`define SSX_DIR_FIRST 7'h05
`define SSX_FILE_DEPTH 128
`define SSX_RESP_OKAY 2'b00
`define SSX_RESP_SLVERR 2'b10
`endif

/* src/ssx_pkg.sv */
`default_nettype none
package ssx_pkg;
   typedef enum logic [2:0] {
      SSX_OP_SUB = 3'h0,
      SSX_OP_SUBB = 3'h1,
      SSX_OP_SWAP = 3'h2,
      SSX_OP_DIR = 3'h3,
      SSX_OP_XORL = 3'h4,
      SSX_OP_XORF = 3'h5
   } ssx_op_t;

   typedef struct packed {
      ssx_op_t op;
      logic dest_file;
      logic [6:0] file_addr;
      logic [7:0] literal;
   } ssx_instr_t;

   typedef struct packed {
      logic z;
      logic dc;
      logic c;
   } ssx_flags_t;

   typedef enum logic [1:0] {
      SSX_BUS_IDLE = 2'b01,
      SSX_BUS_RESP = 2'b10
   } ssx_bus_state_t;
endpackage
`default_nettype wire

/* src/ssx_alu.sv */
`include "ssx_map.svh"
`default_nettype none
module ssx_alu (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [7:0] port_a_direction,
   output logic [7:0] port_b_direction,
   output logic [7:0] port_c_direction
);
   import ssx_pkg::*;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic logic addr_mapped(input logic [7:0] a);
      case (a)
         `SSX_OFF_CTRL, `SSX_OFF_OPERAND, `SSX_OFF_EXEC, `SSX_OFF_WORK,
         `SSX_OFF_STATUS, `SSX_OFF_FADDR, `SSX_OFF_FDATA, `SSX_OFF_DIR,
         `SSX_OFF_RESULT: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   endfunction

   ssx_instr_t instr_q;
   ssx_flags_t flags_q;
   logic [7:0] work_q;
   logic [7:0] result_q;
   logic [6:0] faddr_q;
   logic [7:0] file_q [`SSX_FILE_DEPTH];
   logic [7:0] dir_q [3];

   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_got_q;
   logic w_got_q;
   ssx_bus_state_t wstate_q;
   logic do_write;
   logic exec;

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   assign do_write = aw_got_q && w_got_q && (wstate_q == SSX_BUS_IDLE);
   assign exec = do_write && (awaddr_q == `SSX_OFF_EXEC) && wstrb_q[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_got_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_got_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else begin
         if (do_write) begin
            aw_got_q <= 1'b0;
         end
         s_axi_awready <= !aw_got_q && (wstate_q == SSX_BUS_IDLE) && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_got_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_got_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else begin
         if (do_write) begin
            w_got_q <= 1'b0;
         end
         s_axi_wready <= !w_got_q && (wstate_q == SSX_BUS_IDLE) && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstate_q <= SSX_BUS_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SSX_RESP_OKAY;
      end else begin
         case (wstate_q)
            SSX_BUS_IDLE: begin
               if (do_write) begin
                  wstate_q <= SSX_BUS_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= addr_mapped(awaddr_q) ? `SSX_RESP_OKAY : `SSX_RESP_SLVERR;
               end
            end
            SSX_BUS_RESP: begin
               if (s_axi_bready) begin
                  wstate_q <= SSX_BUS_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wstate_q <= SSX_BUS_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Datapath
   // ---------------------------------------------------------------
   logic [7:0] fval;
   logic cin;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] res;
   logic is_sub;
   logic to_work;
   logic to_file;
   logic upd_z;

   assign fval = file_q[instr_q.file_addr];
   // Borrow form feeds the carry in; plain form adds the two's complement one
   assign cin = (instr_q.op == SSX_OP_SUBB) ? flags_q.c : 1'b1;
   assign sum9 = {1'b0, fval} + {1'b0, ~work_q} + {8'h00, cin};
   assign sum5 = {1'b0, fval[3:0]} + {1'b0, ~work_q[3:0]} + {4'h0, cin};
   assign is_sub = (instr_q.op == SSX_OP_SUB) || (instr_q.op == SSX_OP_SUBB);

   always_comb begin
      res = 8'h00;
      to_work = 1'b0;
      to_file = 1'b0;
      upd_z = 1'b0;
      case (instr_q.op)
         SSX_OP_SUB, SSX_OP_SUBB: begin
            res = sum9[7:0];
            upd_z = 1'b1;
         end
         SSX_OP_SWAP: res = {fval[3:0], fval[7:4]};
         SSX_OP_XORL: begin
            res = work_q ^ instr_q.literal;
            upd_z = 1'b1;
         end
         SSX_OP_XORF: begin
            res = work_q ^ fval;
            upd_z = 1'b1;
         end
         default: res = 8'h00;
      endcase
      if (instr_q.op == SSX_OP_XORL) begin
         to_work = 1'b1;
      end else if (is_sub || instr_q.op == SSX_OP_SWAP || instr_q.op == SSX_OP_XORF) begin
         to_work = !instr_q.dest_file;
         to_file = instr_q.dest_file;
      end
   end

   // ---------------------------------------------------------------
   // Control and operand registers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_q <= '{op: SSX_OP_SUB, dest_file: 1'b0, file_addr: 7'h00, literal: 8'h00};
         faddr_q <= 7'h00;
      end else if (do_write) begin
         if (awaddr_q == `SSX_OFF_CTRL && wstrb_q[0]) begin
            instr_q.op <= ssx_op_t'(wdata_q[`SSX_CTRL_OP_LSB +: 3]);
            instr_q.dest_file <= wdata_q[`SSX_CTRL_DEST_BIT];
         end
         if (awaddr_q == `SSX_OFF_OPERAND && wstrb_q[0]) begin
            instr_q.file_addr <= wdata_q[`SSX_OPND_FILE_LSB +: 7];
         end
         if (awaddr_q == `SSX_OFF_OPERAND && wstrb_q[1]) begin
            instr_q.literal <= wdata_q[`SSX_OPND_LIT_LSB +: 8];
         end
         if (awaddr_q == `SSX_OFF_FADDR && wstrb_q[0]) begin
            faddr_q <= wdata_q[6:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Working register, flags and last result
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         work_q <= `SSX_RST_BYTE;
         flags_q <= 3'b000;
         result_q <= `SSX_RST_BYTE;
      end else if (exec) begin
         result_q <= res;
         if (to_work) begin
            work_q <= res;
         end
         if (is_sub) begin
            flags_q.c <= sum9[8];
            flags_q.dc <= sum5[4];
         end
         if (upd_z) begin
            flags_q.z <= (res == 8'h00);
         end
      end else if (do_write) begin
         if (awaddr_q == `SSX_OFF_WORK && wstrb_q[0]) begin
            work_q <= wdata_q[7:0];
         end
         if (awaddr_q == `SSX_OFF_STATUS && wstrb_q[0]) begin
            flags_q.c <= wdata_q[`SSX_STAT_C_BIT];
            flags_q.dc <= wdata_q[`SSX_STAT_DC_BIT];
            flags_q.z <= wdata_q[`SSX_STAT_Z_BIT];
         end
      end
   end

   // ---------------------------------------------------------------
   // File registers
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < `SSX_FILE_DEPTH; i++) begin
            file_q[i] <= `SSX_RST_BYTE;
         end
      end else if (exec && to_file) begin
         file_q[instr_q.file_addr] <= res;
      end else if (do_write && awaddr_q == `SSX_OFF_FDATA && wstrb_q[0]) begin
         file_q[faddr_q] <= wdata_q[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Port direction registers
   // ---------------------------------------------------------------
   for (genvar p = 0; p < 3; p++) begin : g_dir
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            dir_q[p] <= `SSX_RST_DIR;
         end else if (exec && instr_q.op == SSX_OP_DIR
                      && instr_q.file_addr == `SSX_DIR_FIRST + 7'(p)) begin
            dir_q[p] <= work_q;
         end
      end
   end

   assign port_a_direction = dir_q[0];
   assign port_b_direction = dir_q[1];
   assign port_c_direction = dir_q[2];

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr)
         `SSX_OFF_CTRL: rd_mux = {28'h0000000, instr_q.dest_file, instr_q.op};
         `SSX_OFF_OPERAND: rd_mux = {16'h0000, instr_q.literal, 1'b0, instr_q.file_addr};
         `SSX_OFF_WORK: rd_mux = {24'h000000, work_q};
         `SSX_OFF_STATUS: rd_mux = {29'h00000000, flags_q.z, flags_q.dc, flags_q.c};
         `SSX_OFF_FADDR: rd_mux = {25'h0000000, faddr_q};
         `SSX_OFF_FDATA: rd_mux = {24'h000000, file_q[faddr_q]};
         `SSX_OFF_DIR: rd_mux = {8'h00, dir_q[2], dir_q[1], dir_q[0]};
         `SSX_OFF_RESULT: rd_mux = {24'h000000, result_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SSX_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= addr_mapped(s_axi_araddr) ? `SSX_RESP_OKAY : `SSX_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* tb/ssx_alu_properties.sv */
`default_nettype none
module ssx_alu_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] port_a_direction,
   input wire logic [7:0] port_b_direction,
   input wire logic [7:0] port_c_direction
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_dir_a_load: assert property ($changed(port_a_direction) |-> $rose(s_axi_bvalid))
      else $error("port a direction changed outside a write");
   a_dir_b_load: assert property ($changed(port_b_direction) |-> $rose(s_axi_bvalid))
      else $error("port b direction changed outside a write");
   a_dir_c_load: assert property ($changed(port_c_direction) |-> $rose(s_axi_bvalid))
      else $error("port c direction changed outside a write");
   a_one_port: assert property ($changed(port_a_direction) |->
      $stable(port_b_direction) && $stable(port_c_direction))
      else $error("two direction registers changed together");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready && s_axi_bready |-> ##2 s_axi_bvalid ##1 !s_axi_bvalid)
      else $error("write response out of time");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready && s_axi_rready
      |=> s_axi_rvalid ##1 !s_axi_rvalid)
      else $error("read response out of time");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_dir_b: cover property ($changed(port_b_direction));
endmodule
bind ssx_alu ssx_alu_properties i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .port_a_direction, .port_b_direction, .port_c_direction);
`default_nettype wire

/* tb/tb_top.sv */
`include "ssx_map.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ssx_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rdv;
   logic [7:0] port_a_direction, port_b_direction, port_c_direction;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int seed = 32'h975c8d37;
   int w, f, lit, a, d, c, dc, z, cin, t, r, fl;
   int dir[3];
   ssx_op_t op;

   ssx_alu i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .port_a_direction, .port_b_direction, .port_c_direction);

   always #10 aclk = ~aclk;

   // ------------------------------------------------------------
   // Bus tasks and checks
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      while (!s_axi_bvalid) @(posedge aclk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] ad);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      dir = '{255, 255, 255};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 150; i++) begin
         op = ssx_op_t'(i % 8);
         w = $random(seed) & 255;
         f = (i % 5 == 0) ? w : $random(seed) & 255;
         lit = (i % 4 == 0) ? w : $random(seed) & 255;
         fl = $random(seed) & 7;
         d = $random(seed) & 1;
         a = (i % 7 < 2) ? 127 * (i % 7) : $random(seed) & 127;
         if (op == SSX_OP_DIR) a = 4 + (i / 8) % 5;
         wr(`SSX_OFF_WORK, w);
         wr(`SSX_OFF_STATUS, fl);
         wr(`SSX_OFF_FADDR, a);
         wr(`SSX_OFF_FDATA, f);
         wr(`SSX_OFF_CTRL, op + 8 * d);
         wr(`SSX_OFF_OPERAND, lit * 256 + a);
         wr(`SSX_OFF_EXEC, 1);
         chk("exec bresp", `SSX_RESP_OKAY, rsp);
         c = fl & 1;
         dc = (fl >> 1) & 1;
         z = fl >> 2;
         cin = (op == SSX_OP_SUB) ? 1 : c;
         case (op)
            SSX_OP_SUB, SSX_OP_SUBB: begin
               t = f + (255 - w) + cin;
               r = t & 255;
               c = t >> 8;
               dc = ((f & 15) + (15 - (w & 15)) + cin) >> 4;
               z = (r == 0);
            end
            SSX_OP_SWAP: r = ((f << 4) | (f >> 4)) & 255;
            SSX_OP_DIR: begin
               r = w;
               if (a >= 5 && a <= 7) dir[a - 5] = w;
            end
            SSX_OP_XORL: begin
               r = w ^ lit;
               z = (r == 0);
            end
            SSX_OP_XORF: begin
               r = w ^ f;
               z = (r == 0);
            end
            default: r = 0;
         endcase
         if (op == SSX_OP_XORL || (op != SSX_OP_DIR && op < 6 && d == 0)) w = r;
         else if (op != SSX_OP_DIR && op < 6) f = r;
         rd(`SSX_OFF_WORK);
         chk("work", w, rdv);
         rd(`SSX_OFF_FDATA);
         chk("file", f, rdv);
         rd(`SSX_OFF_STATUS);
         chk("status", c + 2 * dc + 4 * z, rdv);
         rd(`SSX_OFF_DIR);
         chk("dir", dir[0] + 256 * dir[1] + 65536 * dir[2], rdv);
         chk("ports", dir[0] + 256 * dir[1] + 65536 * dir[2],
            {8'h00, port_c_direction, port_b_direction, port_a_direction});
         rd(`SSX_OFF_RESULT);
         if (op != SSX_OP_DIR) chk("result", r, rdv);
         chk("result rresp", `SSX_RESP_OKAY, rsp);
      end
      $display("test random instructions done");
      wr(8'h40, 32'h5a);
      chk("unmapped bresp", `SSX_RESP_SLVERR, rsp);
      rd(8'h40);
      chk("unmapped rresp", `SSX_RESP_SLVERR, rsp);
      chk("unmapped rdata", 32'h0, rdv);
      $display("test unmapped access done");
      print_verdict();
   end
endmodule
`default_nettype wire
